// File: hdl/fsp_defs.svh
// Constants for the fast serial port pin block
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH
`define FSP_BYTE_W 8
`define FSP_CELL_LAST 6'd52
`define FSP_HDR_BYTES 6'd5
`define FSP_HDR3_IDX 6'd3
`define FSP_IDLE_HDR3 8'h01
`define FSP_IDLE_HDR 8'h00
`define FSP_IDLE_FILL 8'h6a
`define FSP_NULL_PORT 5'd31
`define FSP_MUX_LAST 5'd30
`define FSP_DIR_LAST 5'd3
`define FSP_POLL_HOLD 2'd3
`define FSP_NIB_BITS 4'd4
`define FSP_SER_BITS 4'd1
`define FSP_BYTE_BITS 4'd8
`define FSP_OE_ALL 8'hff
`define FSP_OE_NIB 8'h0f
`define FSP_OE_BIT 8'h01
`define FSP_OE_NONE 8'h00
`define FSP_SYNC_W 26
`endif

// File: hdl/fsp_pkg.sv
// Types shared by the fast serial port pin block
`include "fsp_defs.svh"
package fsp_pkg;
  typedef enum logic [5:0] {
    FSP_M_CSLV = 6'h01,
    FSP_M_CDIR = 6'h02,
    FSP_M_CMUX = 6'h04,
    FSP_M_MII = 6'h08,
    FSP_M_HSER = 6'h10,
    FSP_M_HNIB = 6'h20
  } fsp_mode_e;
  typedef enum logic [3:0] {
    FSP_S_IDLE = 4'b0001,
    FSP_S_POLL = 4'b0010,
    FSP_S_GRANT = 4'b0100,
    FSP_S_SEND = 4'b1000
  } fsp_state_e;
  typedef struct packed {
    logic portAPin31;
    logic portAPin30;
    logic portAPin29;
    logic portAPin28;
    logic rxSoc;
    logic rxClav;
    logic [`FSP_BYTE_W-1:0] txd;
    logic [`FSP_BYTE_W-1:0] rxd;
  } fsp_pins_s;
  typedef struct packed {
    logic valid;
    logic soc;
    logic [`FSP_BYTE_W-1:0] data;
  } fsp_byte_s;
endpackage : fsp_pkg

// File: hdl/fsp_port.sv
// Shared port pins: cell bus master/slave, media-independent, HDLC
// Functional notes
// RULE_01 - Cell mode exists on controller one only; cell data is eight bits.
// RULE_02 - Direct-polling master serves four PHYs, each with own available line.
// RULE_03 - Multiplexed-polling master uses addresses 0 to 30; 31 is null.
// RULE_04 - As master, transmit enable is high exactly while valid cell data.
// RULE_05 - As slave, external master raises transmit enable with valid data.
// RULE_06 - As slave, transmit cell-available only when a whole cell fits.
// RULE_07 - External slave PHY raises cell-available only when a cell fits.
// RULE_08 - As master, start-of-cell marks the cycle of the first byte.
// RULE_09 - As master, receive enable asks for data in following cycle.
// RULE_10 - As slave, receive data driven only in cycle after enable; code loads rxd in the cycle after the synchronised enable, two cycles late.
// RULE_11 - HDLC: request-to-send low; granted only when clear-to-send low.
// RULE_12 - HDLC nibble moves four bits per transfer, serial moves one.
// RULE_13 - Media-independent transmit enable high for whole transmission.
// RULE_14 - Media-independent transmit error raised to force an error.
// RULE_15 - External PHY raises collision when collision detected.
// RULE_16 - External PHY raises carrier sense on cable activity.
// RULE_17 - Cells are 53 bytes; idle cells sent when no data ready.
// RULE_18 - As slave, receive cell-available only when whole cell ready.
// RULE_19 - Cell bus bit 0 is least significant, bit 7 most.
// RULE_20 - One mode at a time sets function and direction of pins.
`timescale 1ns/1ns
`default_nettype none
`include "fsp_defs.svh"
module fsp_port (
  input wire logic clk,
  input wire logic rst,
  input wire fsp_pkg::fsp_mode_e mode,
  input wire fsp_pkg::fsp_pins_s pinIn,
  output fsp_pkg::fsp_pins_s pinOut,
  output fsp_pkg::fsp_pins_s pinOe,
  input wire logic [3:1] txCellAvailDirect,
  input wire logic ctsN,
  output logic [4:0] phyAddr,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txLast,
  input wire logic txErr,
  output logic txReady,
  input wire logic cellRoom,
  input wire logic cellReady,
  output fsp_pkg::fsp_byte_s rxOut,
  output logic colDetect,
  output logic carrierSense
);
  import fsp_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [3:0] fsp_step(input fsp_mode_e m);
    return (m == FSP_M_HSER) ? `FSP_SER_BITS : `FSP_NIB_BITS; // RULE_12
  endfunction : fsp_step

  function automatic logic [7:0] fsp_chunk(input logic [7:0] d, input fsp_mode_e m);
    return (m == FSP_M_HSER) ? (d & `FSP_OE_BIT) : (d & `FSP_OE_NIB); // RULE_12
  endfunction : fsp_chunk

  function automatic logic [7:0] fsp_idle_byte(input logic [5:0] idx);
    if (idx == `FSP_HDR3_IDX) return `FSP_IDLE_HDR3;
    return (idx < `FSP_HDR_BYTES) ? `FSP_IDLE_HDR : `FSP_IDLE_FILL;
  endfunction : fsp_idle_byte

  function automatic logic [4:0] fsp_next_idx(input logic [4:0] idx, input logic mux);
    logic [4:0] last;
    last = mux ? `FSP_MUX_LAST : `FSP_DIR_LAST;
    return (idx >= last) ? 5'h00 : idx + 5'h01; // RULE_02 RULE_03
  endfunction : fsp_next_idx

  // ==========================================================
  // Pin synchronisers
  logic [`FSP_SYNC_W-1:0] syncQ;
  fsp_pins_s pinS;
  logic [3:1] clavS;
  logic ctsNS;

  fsp_sync #(.WIDTH(`FSP_SYNC_W)) u_sync (
    .clk(clk),
    .rst(rst),
    // Inverted so the reset value reads as not clear to send
    .d({pinIn, txCellAvailDirect, ~ctsN}),
    .q(syncQ)
  );
  assign pinS = fsp_pins_s'(syncQ[`FSP_SYNC_W-1:4]);
  assign clavS = syncQ[3:1];
  assign ctsNS = !syncQ[0];

  // ==========================================================
  // Mode decode
  logic isSlave, isDir, isMux, isMaster, isMii, isHdlc;
  assign isSlave = (mode == FSP_M_CSLV); // RULE_01 RULE_20
  assign isDir = (mode == FSP_M_CDIR);
  assign isMux = (mode == FSP_M_CMUX);
  assign isMaster = isDir | isMux;
  assign isMii = (mode == FSP_M_MII);
  assign isHdlc = (mode == FSP_M_HSER) | (mode == FSP_M_HNIB);

  // ==========================================================
  // Control
  fsp_state_e state;
  logic [5:0] byteCnt;
  logic [4:0] pollIdx;
  logic [1:0] pollHold;
  logic cellUser, frameDone, txErFlag;
  logic [3:0] bitsLeft;
  logic [7:0] shiftReg;
  logic [7:0] txdReg, rxdReg;
  logic txEnbReg, txSocReg, rxEnbReg, rxSocReg, txClavReg, rxClavReg;
  logic [2:0] rxPipe;
  logic clavSel, mSend, sTake, take, shifting;

  // Selected PHY's available line
  assign clavSel = isMux ? pinS.portAPin30 :
                   pollIdx[1:0] == 2'h0 ? pinS.portAPin30 : clavS[pollIdx[1:0]]; // RULE_02
  assign mSend = isMaster && state == FSP_S_SEND && (!cellUser || txValid);
  assign sTake = isSlave && pinS.portAPin28 && txValid;
  assign take = (isMii || isHdlc) && txValid &&
                ((state == FSP_S_IDLE && isMii) || (state == FSP_S_GRANT && !ctsNS) ||
                 (state == FSP_S_SEND && bitsLeft == 4'h0 && !frameDone)); // RULE_11
  assign shifting = (isMii || isHdlc) && state == FSP_S_SEND && bitsLeft != 4'h0;
  assign txReady = (mSend && cellUser) || sTake || take;
  assign phyAddr = pollIdx;

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= FSP_S_IDLE;
      pollIdx <= 5'h00;
      pollHold <= 2'h0;
      cellUser <= 1'b0;
    end else begin
      case (state)
        FSP_S_IDLE: begin
          if (isMaster) begin
            state <= FSP_S_POLL;
            pollHold <= 2'h0;
          end else if (take) begin
            state <= FSP_S_SEND;
          end else if (isHdlc && txValid) begin
            state <= FSP_S_GRANT; // RULE_11
          end
        end
        FSP_S_GRANT: begin
          if (take) begin
            state <= FSP_S_SEND;
          end else if (!isHdlc) begin
            state <= FSP_S_IDLE;
          end
        end
        FSP_S_POLL: begin
          // Hold each address long enough for the synchronised answer
          if (!isMaster) begin
            state <= FSP_S_IDLE;
          end else if (pollHold != `FSP_POLL_HOLD) begin
            pollHold <= pollHold + 2'h1;
          end else if (clavSel) begin
            state <= FSP_S_SEND;
            cellUser <= txValid; // RULE_17
          end else begin
            pollHold <= 2'h0;
            pollIdx <= fsp_next_idx(pollIdx, isMux); // RULE_03
          end
        end
        FSP_S_SEND: begin
          if (isMaster) begin
            if (mSend && byteCnt == `FSP_CELL_LAST) begin
              state <= FSP_S_POLL;
              pollHold <= 2'h0;
              pollIdx <= fsp_next_idx(pollIdx, isMux);
            end
          end else if (bitsLeft == 4'h0 && frameDone) begin
            state <= FSP_S_IDLE;
          end
        end
        default: state <= FSP_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || state == FSP_S_POLL) begin
      byteCnt <= 6'h00;
    end else if (mSend || sTake) begin
      byteCnt <= (byteCnt == `FSP_CELL_LAST) ? 6'h00 : byteCnt + 6'h01; // RULE_17
    end
  end

  // ==========================================================
  // Transmit data path
  always_ff @(posedge clk) begin
    if (rst) begin
      shiftReg <= 8'h00;
      bitsLeft <= 4'h0;
      frameDone <= 1'b0;
    end else if (take) begin
      shiftReg <= txData >> fsp_step(mode);
      bitsLeft <= `FSP_BYTE_BITS - fsp_step(mode); // RULE_12
      frameDone <= txLast;
    end else if (shifting) begin
      shiftReg <= shiftReg >> fsp_step(mode);
      bitsLeft <= bitsLeft - fsp_step(mode);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txdReg <= 8'h00;
      txEnbReg <= 1'b0;
      txSocReg <= 1'b0;
    end else begin
      txEnbReg <= mSend; // RULE_04
      txSocReg <= mSend && byteCnt == 6'h00; // RULE_08
      if (mSend) begin
        txdReg <= cellUser ? txData : fsp_idle_byte(byteCnt); // RULE_17 RULE_19
      end else if (take) begin
        txdReg <= fsp_chunk(txData, mode);
      end else if (shifting) begin
        txdReg <= fsp_chunk(shiftReg, mode);
      end
    end
  end

  always_ff @(posedge clk) begin
    // A first byte taken straight from idle must keep its error flag
    if (rst) begin
      txErFlag <= 1'b0;
    end else if (take) begin
      txErFlag <= txErr; // RULE_14
    end else if (state == FSP_S_IDLE) begin
      txErFlag <= 1'b0;
    end
  end

  // ==========================================================
  // Receive side and slave answers
  always_ff @(posedge clk) begin
    if (rst) begin
      rxEnbReg <= 1'b0;
      rxPipe <= 3'h0;
      rxOut <= '0;
      txClavReg <= 1'b0;
      rxClavReg <= 1'b0;
      rxdReg <= 8'h00;
      rxSocReg <= 1'b0;
      colDetect <= 1'b0;
      carrierSense <= 1'b0;
    end else begin
      rxEnbReg <= isMaster && pinS.rxClav && cellRoom; // RULE_09
      // Sync delay adds two cycles to the PHY's one
      rxPipe <= {rxPipe[1:0], rxEnbReg && isMaster};
      txClavReg <= cellRoom; // RULE_06
      rxClavReg <= cellReady; // RULE_18
      colDetect <= isMii && pinS.portAPin31; // RULE_15
      carrierSense <= isMii && pinS.portAPin30; // RULE_16
      if (isMaster && rxPipe[2]) begin
        rxOut <= '{valid: 1'b1, soc: pinS.rxSoc, data: pinS.rxd}; // RULE_09
      end else if (isSlave && pinS.portAPin31) begin
        rxOut <= '{valid: 1'b1, soc: pinS.portAPin29, data: pinS.txd}; // RULE_05
      end else begin
        rxOut.valid <= 1'b0;
      end
      if (sTake) begin
        rxdReg <= txData; // RULE_10
        rxSocReg <= byteCnt == 6'h00;
      end
    end
  end

  // ==========================================================
  // Pin function and direction per mode
  always_comb begin
    pinOut.portAPin31 = txEnbReg;
    pinOut.portAPin30 = isSlave ? txClavReg : !(state == FSP_S_GRANT || state == FSP_S_SEND);
    pinOut.portAPin29 = isMii ? txErFlag : txSocReg; // RULE_14
    pinOut.portAPin28 = isMaster ? rxEnbReg : (isMii && state == FSP_S_SEND); // RULE_13
    pinOut.rxSoc = rxSocReg;
    pinOut.rxClav = rxClavReg;
    pinOut.txd = txdReg;
    pinOut.rxd = rxdReg;
    pinOe.portAPin31 = isMaster; // RULE_20
    pinOe.portAPin30 = isSlave || isHdlc;
    pinOe.portAPin29 = isMaster || isMii;
    pinOe.portAPin28 = isMaster || isMii;
    pinOe.rxSoc = isSlave;
    pinOe.rxClav = isSlave;
    pinOe.txd = isMaster ? `FSP_OE_ALL : (isMii || mode == FSP_M_HNIB) ? `FSP_OE_NIB :
                (mode == FSP_M_HSER) ? `FSP_OE_BIT : `FSP_OE_NONE;
    pinOe.rxd = isSlave ? `FSP_OE_ALL : `FSP_OE_NONE;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  soc_with_enable_a: assert property (isMaster && pinOut.portAPin29 |-> pinOut.portAPin31) // RULE_08
    else $error("start of cell without transmit enable");
  enable_data_a: assert property (mSend |=> pinOut.portAPin31 && // RULE_04
    (!$past(cellUser) || pinOut.txd == $past(txData)))
    else $error("master byte sent without enable");
  mux_null_a: assert property (isMux |-> phyAddr != `FSP_NULL_PORT) // RULE_03
    else $error("null port addressed");
  cell_end_a: assert property (mSend && byteCnt == `FSP_CELL_LAST |=> state == FSP_S_POLL) // RULE_17
    else $error("cell length wrong");
  slave_clav_a: assert property (isSlave && $past(isSlave) |-> pinOut.portAPin30 == $past(cellRoom)) // RULE_06
    else $error("transmit cell-available wrong");
  rx_clav_a: assert property (isSlave |=> pinOut.rxClav == $past(cellReady)) // RULE_18
    else $error("receive cell-available wrong");
  slave_drive_a: assert property (isSlave && $changed(pinOut.rxd) |-> $past(pinS.portAPin28)) // RULE_10
    else $error("receive data changed without enable");
  master_sample_a: assert property (isMaster && rxOut.valid |-> $past(pinOut.portAPin28, 4)) // RULE_09
    else $error("receive sample without earlier enable");
  rts_grant_a: assert property (isHdlc && $rose(state == FSP_S_SEND) |-> !$past(ctsNS)) // RULE_11
    else $error("send without clear-to-send");
  serial_step_a: assert property (take && mode == FSP_M_HSER |=> bitsLeft == 4'd7) // RULE_12
    else $error("serial step not one bit");
  mii_enable_a: assert property (isMii && take |=> pinOut.portAPin28 [*2]) // RULE_13
    else $error("transmit enable dropped mid byte");
  pin_dir_a: assert property (pinOe.portAPin31 |-> isMaster) // RULE_20
    else $error("pin driven in wrong mode");

  cell_sent_c: cover property (mSend && cellUser && byteCnt == `FSP_CELL_LAST);
  idle_cell_c: cover property (mSend && !cellUser && byteCnt == `FSP_CELL_LAST);
  slave_byte_c: cover property (sTake ##1 isSlave);
  hdlc_done_c: cover property (isHdlc && state == FSP_S_SEND ##1 state == FSP_S_IDLE);
endmodule : fsp_port
`default_nettype wire

// File: hdl/fsp_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module fsp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;
  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '0;
      q <= '0;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule : fsp_sync
`default_nettype wire

// File: testbench/fsp_phy_model.sv
// Far-side model: external cell-bus master or slave PHY, Ethernet PHY
`timescale 1ns/1ns
`default_nettype none
module fsp_phy_model import fsp_pkg::*; (
  input wire logic clk,
  input wire fsp_pkg::fsp_mode_e mode,
  input wire fsp_pkg::fsp_pins_s pinOut,
  input wire logic clavOn,
  input wire logic lineA,
  input wire logic lineB,
  input wire logic [7:0] rndByte,
  output fsp_pkg::fsp_pins_s pinIn
);
  // =====================================
  // Bytes sent toward the block, in order
  logic [8:0] rxQ[$];
  logic [5:0] idx = 6'h00;
  initial pinIn = '0;
  always @(posedge clk) begin
    case (mode)
      FSP_M_CSLV: begin
        pinIn.portAPin31 <= lineA;
        pinIn.portAPin28 <= lineB;
        pinIn.portAPin29 <= lineA && idx == 6'h00;
        pinIn.txd <= lineA ? rndByte : ~pinIn.txd;
        if (lineA) begin
          rxQ.push_back({idx == 6'h00, rndByte});
          idx <= (idx == 6'h34) ? 6'h00 : idx + 6'h01;
        end
      end
      FSP_M_CDIR, FSP_M_CMUX: begin
        pinIn.portAPin30 <= clavOn;
        pinIn.rxClav <= 1'b1;
        if (pinOut.portAPin28 === 1'b1) begin
          pinIn.rxd <= rndByte;
          pinIn.rxSoc <= idx == 6'h00;
          rxQ.push_back({idx == 6'h00, rndByte});
          idx <= (idx == 6'h34) ? 6'h00 : idx + 6'h01;
        end else begin
          // Released lines toggle so stale data never looks valid
          pinIn.rxd <= ~pinIn.rxd;
          pinIn.rxSoc <= ~pinIn.rxSoc;
        end
      end
      FSP_M_MII: begin
        pinIn.portAPin31 <= lineA;
        pinIn.portAPin30 <= lineB;
      end
      default: ;
    endcase
  end
endmodule : fsp_phy_model
`default_nettype wire

// File: testbench/fsp_port_tb.sv
// Self-checking bench for the fast serial port pin block
`timescale 1ns/1ns
`default_nettype none
`include "fsp_defs.svh"
module fsp_port_tb;
  import fsp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  fsp_mode_e mode = FSP_M_CDIR;
  fsp_pins_s pinIn, pinOut, pinOe;
  fsp_byte_s rxOut;
  logic [3:1] txCellAvailDirect = 3'h0;
  logic ctsN = 1'b1, txValid = 1'b0, txLast = 1'b0, txErr = 1'b0, txReady;
  logic [7:0] txData = 8'h00, rndByte = 8'h00;
  logic cellRoom = 1'b0, cellReady = 1'b0, colDetect, carrierSense;
  logic clavOn = 1'b0, lineA = 1'b0, lineB = 1'b0, srcOn = 1'b0, oneShot = 1'b0;
  logic quiet = 1'b1, taken = 1'b0, prevRoom = 1'b0, prevReady = 1'b0, half = 1'b0;
  logic [4:0] phyAddr;
  logic [8:0] takeQ[$];
  logic [8:0] cidx = 9'h000, lo = 9'h000, e;
  logic [3:0] colH = 4'h0, crsH = 4'h0;
  logic [31:0] r;
  int seed = 32'h3374182c;
  int bad_count = 0, check_count = 0, cells = 0;

  fsp_port fsp_port_i (.clk, .rst, .mode, .pinIn, .pinOut, .pinOe, .txCellAvailDirect,
    .ctsN, .phyAddr, .txValid, .txData, .txLast, .txErr, .txReady, .cellRoom,
    .cellReady, .rxOut, .colDetect, .carrierSense);
  fsp_phy_model fsp_phy_model_i (.clk, .mode, .pinOut, .clavOn, .lineA, .lineB,
    .rndByte, .pinIn);

  always #25 clk = ~clk;

  // =====================================
  // Helpers
  task automatic chk(input string what, input logic [8:0] ex, input logic [8:0] got);
    check_count++;
    if (got !== ex) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, ex, got);
    end
  endtask : chk
  // An empty queue yields unknowns, so a surplus byte always mismatches
  function automatic logic [8:0] pop_take();
    return takeQ.size() ? takeQ.pop_front() : 'x;
  endfunction : pop_take
  function automatic logic [8:0] idle_byte(input logic [8:0] i);
    if (i == 9'd3) return {1'b0, `FSP_IDLE_HDR3};
    if (i < 9'd5) return {1'b0, `FSP_IDLE_HDR};
    return {1'b0, `FSP_IDLE_FILL};
  endfunction : idle_byte
  function automatic logic [7:0] oe_exp(input fsp_mode_e m);
    case (m)
      FSP_M_CSLV: return `FSP_OE_NONE;
      FSP_M_CDIR, FSP_M_CMUX: return `FSP_OE_ALL;
      FSP_M_HSER: return `FSP_OE_BIT;
      default: return `FSP_OE_NIB;
    endcase
  endfunction : oe_exp
  task automatic end_of_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // =====================================
  // Stimulus on the falling edge
  always @(negedge clk) begin
    r = $random(seed);
    rndByte <= r[7:0];
    {lineA, lineB, cellRoom, cellReady} <= quiet ? 4'h0 : r[11:8];
    txCellAvailDirect <= r[14:12];
    clavOn <= r[15];
    if (taken) begin
      txData <= r[23:16];
      txErr <= r[24];
      txLast <= oneShot | (r[27:25] == 3'd0);
      if (oneShot) srcOn = 1'b0;
    end
    txValid <= srcOn;
  end

  // =====================================
  // Monitors on the rising edge
  always @(posedge clk) begin
    if (!rst) begin
      chk("txd drive", 9'(oe_exp(mode)), 9'(pinOe.txd));
      chk("rxd drive", 9'(mode == FSP_M_CSLV ? `FSP_OE_ALL : `FSP_OE_NONE),
        9'(pinOe.rxd));
      if (mode == FSP_M_CDIR || mode == FSP_M_CMUX) begin
        chk("poll address", 9'd1, 9'(phyAddr <= (mode == FSP_M_CDIR ? 5'd3 : 5'd30)));
        if (pinOut.portAPin31 === 1'b1) begin
          if (pinOut.portAPin29 === 1'b1) begin
            if (cells > 0) chk("cell length", 9'd52, cidx);
            cidx = 9'd0;
            cells++;
          end else cidx++;
          e = srcOn ? pop_take() : idle_byte(cidx);
          chk("cell byte", {1'b0, e[7:0]}, 9'(pinOut.txd));
        end
      end
      if (mode != FSP_M_MII && mode != FSP_M_HSER && mode != FSP_M_HNIB
          && rxOut.valid === 1'b1) begin
        e = fsp_phy_model_i.rxQ.size() ? fsp_phy_model_i.rxQ.pop_front() : 'x;
        chk("rx byte", e, {rxOut.soc, rxOut.data});
      end
      if (mode == FSP_M_CSLV) begin
        chk("cell room", 9'(prevRoom), 9'(pinOut.portAPin30));
        chk("cell ready", 9'(prevReady), 9'(pinOut.rxClav));
        if (taken) begin
          e = pop_take();
          chk("slave rxd", {1'b0, e[7:0]}, 9'(pinOut.rxd));
          chk("slave soc", 9'(cidx == 9'd0), 9'(pinOut.rxSoc));
          cidx = (cidx == 9'd52) ? 9'd0 : cidx + 9'd1;
        end
      end
      if (mode == FSP_M_MII) begin
        chk("collision", 9'(colH[2]), 9'(colDetect));
        chk("carrier", 9'(crsH[2]), 9'(carrierSense));
        if (pinOut.portAPin28 === 1'b1) begin
          if (half) chk("mii byte", pop_take(), {lo[8], pinOut.txd[3:0], lo[3:0]});
          else lo = {pinOut.portAPin29, 4'h0, pinOut.txd[3:0]};
          half = ~half;
        end else half = 1'b0;
      end
    end
    // Three flops from pin to flag: two to synchronise, one to register
    colH = {colH[2:0], pinIn.portAPin31};
    crsH = {crsH[2:0], pinIn.portAPin30};
    prevRoom = cellRoom;
    prevReady = cellReady;
    taken = txReady === 1'b1 && txValid;
    if (taken) takeQ.push_back({txErr, txData});
  end

  // =====================================
  // Sequences
  task automatic run(input fsp_mode_e m, input logic s, input int n);
    @(negedge clk);
    quiet = 1'b1;
    rst = 1'b1;
    @(negedge clk);
    mode = m;
    srcOn = s;
    oneShot = 1'b0;
    repeat (4) @(negedge clk);
    takeQ.delete();
    fsp_phy_model_i.rxQ.delete();
    fsp_phy_model_i.idx = 6'h00;
    cells = 0;
    cidx = 9'd0;
    rst = 1'b0;
    repeat (6) @(negedge clk);
    quiet = 1'b0;
    repeat (n) @(negedge clk);
  endtask : run

  task automatic hdlc(input fsp_mode_e m, input int n);
    logic [7:0] b, msk;
    int w;
    msk = (n == 2) ? 8'h0f : 8'h01;
    run(m, 1'b0, 2);
    ctsN = 1'b1;
    txLast = 1'b1;
    oneShot = 1'b1;
    srcOn = 1'b1;
    repeat (8) @(negedge clk);
    chk("rts low", 9'd0, 9'(pinOut.portAPin30));
    chk("held back", 9'd0, 9'(takeQ.size()));
    ctsN = 1'b0;
    w = 0;
    while (takeQ.size() == 0 && w < 20) begin
      @(negedge clk);
      w++;
    end
    b = takeQ.size() ? takeQ[0][7:0] : 8'hxx;
    for (int i = 0; i < n; i++) begin
      chk("hdlc data", 9'((b >> (i * (8 / n))) & msk), 9'(pinOut.txd & msk));
      @(negedge clk);
    end
    ctsN = 1'b1;
    w = 0;
    while (pinOut.portAPin30 !== 1'b1 && w < 20) begin
      @(negedge clk);
      w++;
    end
    chk("rts release", 9'd1, 9'(pinOut.portAPin30));
  endtask : hdlc

  initial begin
    run(FSP_M_CDIR, 1'b0, 400);
    run(FSP_M_CMUX, 1'b1, 400);
    run(FSP_M_CSLV, 1'b1, 300);
    run(FSP_M_MII, 1'b1, 300);
    hdlc(FSP_M_HSER, 8);
    hdlc(FSP_M_HNIB, 2);
    end_of_test();
  end

  // Whole run is under 2000 cycles; three times that means a hang
  initial begin
    #(50 * 6000);
    bad_count++;
    end_of_test();
  end
endmodule : fsp_port_tb
`default_nettype wire
